// file: verilog/ang_regs.sv
`include "ang_defs.svh"
`default_nettype none

// Functional notes
// - writable pause advertisement bit, resets to zero.
// - 100TX full-duplex advertisement resets to speed strap AND duplex strap.
// - 100TX advertisement resets to speed strap; T4 advertisement reads zero.
// - 10BASE-T advertisement bit is writable and resets to one.
// - 10BASE-T full-duplex advertisement resets to the duplex strap.
// - selector fields reset to 00001; advertised writable, partner read-only.
// - partner ability read-only, resets to 0001; acknowledge set on code word.
// - partner remote fault, next page and technology abilities reported read-only.
// - partner pause ability reported as a read-only two-bit field.
// - parallel detection fault flag latches high, resets to zero.
// - partner autoneg-able bit read-only, follows link input unregistered; partner next-page-able bit read-only, resets zero.
// - local next-page-able bit always reads one.
// - page received flag latches high on each new partner page.
// - software writes next-page-follows bit; resets to zero.
// - writable message page type bit, resets to one.
// - writable second acknowledge bit, resets to zero.
// - outgoing toggle bit read-only, mirrors previous transmitted toggle.
// - writable 11-bit outgoing message field, resets to one.
// - partner next page captured into read-only fields, reset zero.
// - partner next page toggle reported read-only as received.
// - 16-bit read-only receive error counter, resets to zero.
// - writable jabber interrupt enable, resets to zero.
module ang_regs
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              speed_strap,
    input  wire logic              duplex_strap,
    input  wire ang_pkg::ang_mreq_t mreq,
    input  wire ang_pkg::ang_link_t link_in,
    output logic [15:0]            mgmt_rdata_r,
    output logic                   mgmt_rvalid_r,
    output logic [15:0]            adv_word_r,
    output logic [15:0]            np_tx_word_r,
    output logic                   jabber_irq_en_r
);

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    logic        strap_done_r;
    logic [15:0] lp_ability_r;
    logic [15:0] lp_np_r;
    logic [15:0] rx_err_cnt_r;
    logic        pd_fault_r;
    logic        page_rcvd_r;
    logic        tx_toggle_r;
    logic [15:0] exp_word;
    logic [15:0] rdata_nxt;
    logic        wr_adv;
    logic        wr_nptx;
    logic        wr_ics;
    logic        rd_exp;

    assign wr_adv  = mreq.wr && hit(mreq.addr, `ANG_OFF_ADV);
    assign wr_nptx = mreq.wr && hit(mreq.addr, `ANG_OFF_NPTX);
    assign wr_ics  = mreq.wr && hit(mreq.addr, `ANG_OFF_ICS);
    assign rd_exp  = mreq.rd && hit(mreq.addr, `ANG_OFF_EXP);

    // straps are sampled on the first edge after reset release, never under reset
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            strap_done_r <= 1'b0;
        else
            strap_done_r <= 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            adv_word_r <= `ANG_ADV_RST;
        else if (!strap_done_r)
        begin
            adv_word_r[`ANG_ADV_TXFD] <= speed_strap & duplex_strap;
            adv_word_r[`ANG_ADV_TX]   <= speed_strap;
            adv_word_r[`ANG_ADV_10FD] <= duplex_strap;
        end
        else if (wr_adv)
            // reserved and T4 bits stay zero through the mask
            adv_word_r <= mreq.wdata & `ANG_ADV_WMASK;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            np_tx_word_r <= `ANG_NPTX_RST;
        else if (wr_nptx)
            np_tx_word_r <= mreq.wdata & `ANG_NPTX_WMASK;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tx_toggle_r <= 1'b0;
        else
            tx_toggle_r <= link_in.tx_toggle;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            jabber_irq_en_r <= 1'b0;
        else if (wr_ics)
            jabber_irq_en_r <= mreq.wdata[`ANG_ICS_JAB_EN];
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            lp_ability_r <= `ANG_LPA_RST;
        else if (link_in.base_vld)
            // acknowledge forced high: a word arrived
            lp_ability_r <= (link_in.word & `ANG_LPA_MASK) | `ANG_LPA_ACK;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            lp_np_r <= `ANG_LPNP_RST;
        else if (link_in.np_vld)
            lp_np_r <= link_in.word;
    end

    // event wins over the clearing read so nothing is lost
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            pd_fault_r <= 1'b0;
        else
            pd_fault_r <= link_in.pd_fault | (pd_fault_r & ~rd_exp);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            page_rcvd_r <= 1'b0;
        else
            page_rcvd_r <= link_in.page_rcvd | (page_rcvd_r & ~rd_exp);
    end

    // saturates rather than wraps so a busy link never reads as clean
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rx_err_cnt_r <= `ANG_RXERR_RST;
        else if (link_in.rx_er && rx_err_cnt_r != `ANG_RXERR_MAX)
            rx_err_cnt_r <= rx_err_cnt_r + 16'h0001;
    end

    always_comb
    begin
        exp_word                  = 16'h0000;
        exp_word[`ANG_EXP_PD]     = pd_fault_r;
        exp_word[`ANG_EXP_LPNP]   = lp_ability_r[`ANG_LPA_NP];
        exp_word[`ANG_EXP_NPABLE] = 1'b1;
        exp_word[`ANG_EXP_PR]     = page_rcvd_r;
        exp_word[`ANG_EXP_LPAN]   = link_in.an_able;
    end

    always_comb
    begin
        rdata_nxt = 16'h0000;
        unique case (1'b1)
            hit(mreq.addr, `ANG_OFF_ADV):   rdata_nxt = adv_word_r;
            hit(mreq.addr, `ANG_OFF_LPA):   rdata_nxt = lp_ability_r;
            hit(mreq.addr, `ANG_OFF_EXP):   rdata_nxt = exp_word;
            hit(mreq.addr, `ANG_OFF_NPTX):
            begin
                rdata_nxt = np_tx_word_r;
                rdata_nxt[`ANG_NPTX_TOG] = tx_toggle_r;
            end
            hit(mreq.addr, `ANG_OFF_LPNP):  rdata_nxt = lp_np_r;
            hit(mreq.addr, `ANG_OFF_RXERR): rdata_nxt = rx_err_cnt_r;
            hit(mreq.addr, `ANG_OFF_ICS):   rdata_nxt[`ANG_ICS_JAB_EN] = jabber_irq_en_r;
            default:                        rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mgmt_rdata_r  <= 16'h0000;
            mgmt_rvalid_r <= 1'b0;
        end
        else
        begin
            mgmt_rvalid_r <= mreq.rd;
            mgmt_rdata_r  <= mreq.rd ? rdata_nxt : mgmt_rdata_r;
        end
    end

    // checks
    sequence s_read_exp;
        mreq.rd && hit(mreq.addr, `ANG_OFF_EXP);
    endsequence

    // the clearing read and the quiet link must share one cycle, or a new event is kept
    sequence s_rd_idle_exp;
        s_read_exp ##0 (!link_in.pd_fault && !link_in.page_rcvd);
    endsequence

    sequence s_read_rxerr;
        mreq.rd && hit(mreq.addr, `ANG_OFF_RXERR);
    endsequence

    sequence s_read_ics;
        mreq.rd && hit(mreq.addr, `ANG_OFF_ICS);
    endsequence

    a_strap_load_txfd: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(strap_done_r) |-> adv_word_r[`ANG_ADV_TXFD] == $past(speed_strap & duplex_strap))
        else $error("tx full duplex advert not loaded from straps");

    a_strap_load_tx: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(strap_done_r) |-> adv_word_r[`ANG_ADV_TX] == $past(speed_strap)
            && adv_word_r[`ANG_ADV_10FD] == $past(duplex_strap))
        else $error("speed or duplex advert not loaded from straps");

    a_adv_t4_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_adv && strap_done_r |=> !adv_word_r[`ANG_ADV_T4]
            && adv_word_r[`ANG_ADV_PAUSE] == $past(mreq.wdata[`ANG_ADV_PAUSE]))
        else $error("advert write gave wrong t4 or pause");

    a_lpa_ack_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        link_in.base_vld |=> lp_ability_r[14] && lp_ability_r[11:10] == $past(link_in.word[11:10]))
        else $error("partner word not captured with acknowledge");

    a_pd_latch_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        ($rose(pd_fault_r) && !rd_exp) ##1 (!rd_exp && !link_in.pd_fault)[*3] |-> pd_fault_r)
        else $error("parallel fault flag dropped before read");

    a_pr_clear_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_rd_idle_exp |=> !page_rcvd_r && !pd_fault_r && mgmt_rvalid_r)
        else $error("page received flag not cleared by read");

    a_pr_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
        link_in.page_rcvd |=> page_rcvd_r)
        else $error("page received event lost");

    a_rxerr_count: assert property (@(posedge sys_clk) disable iff (!rstn)
        link_in.rx_er && rx_err_cnt_r != `ANG_RXERR_MAX
            |=> rx_err_cnt_r == $past(rx_err_cnt_r) + 16'h0001)
        else $error("receive error not counted");

    a_rxerr_still: assert property (@(posedge sys_clk) disable iff (!rstn)
        !link_in.rx_er |=> $stable(rx_err_cnt_r))
        else $error("receive error counter moved without error");

    a_exp_np_able: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_read_exp |=> mgmt_rvalid_r && mgmt_rdata_r[`ANG_EXP_NPABLE])
        else $error("next page able not reported");

    a_np_tog_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        mreq.rd && hit(mreq.addr, `ANG_OFF_NPTX)
            |=> mgmt_rdata_r[`ANG_NPTX_TOG] == $past(tx_toggle_r))
        else $error("outgoing toggle not mirrored");

    a_jab_en_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_ics |=> jabber_irq_en_r == $past(mreq.wdata[`ANG_ICS_JAB_EN]))
        else $error("jabber enable not written");

    a_adv_rst_val: assert property (@(posedge sys_clk) disable iff (!rstn)
        !strap_done_r |-> adv_word_r[`ANG_ADV_PAUSE] == 1'b0 && adv_word_r[`ANG_ADV_10]
            && adv_word_r[4:0] == 5'h01)
        else $error("advert reset value wrong");

    a_np_rst_val: assert property (@(posedge sys_clk) disable iff (!rstn)
        !strap_done_r |-> np_tx_word_r == `ANG_NPTX_RST)
        else $error("next page reset value wrong");

    a_lp_rst_val: assert property (@(posedge sys_clk) disable iff (!rstn)
        !strap_done_r |-> lp_ability_r == `ANG_LPA_RST && lp_np_r == `ANG_LPNP_RST
            && rx_err_cnt_r == `ANG_RXERR_RST)
        else $error("partner or counter reset value wrong");

    a_flag_rst_val: assert property (@(posedge sys_clk) disable iff (!rstn)
        !strap_done_r |-> !pd_fault_r && !page_rcvd_r && !jabber_irq_en_r)
        else $error("flag reset value wrong");

    a_adv_low_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_adv && strap_done_r
            |=> adv_word_r[`ANG_ADV_10FD:0] == $past(mreq.wdata[`ANG_ADV_10FD:0]))
        else $error("advert low field write lost");

    a_adv_tx_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_adv && strap_done_r
            |=> adv_word_r[`ANG_ADV_TXFD:`ANG_ADV_TX] == $past(mreq.wdata[8:7]))
        else $error("advert tx bits write lost");

    a_adv_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_adv && strap_done_r |=> $stable(adv_word_r))
        else $error("advert changed without write");

    a_adv_ro_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        !adv_word_r[14] && adv_word_r[12:11] == 2'b00 && !adv_word_r[`ANG_ADV_T4])
        else $error("advert read-only bit set");

    a_lpa_fields: assert property (@(posedge sys_clk) disable iff (!rstn)
        link_in.base_vld |=> lp_ability_r[15] == $past(link_in.word[15])
            && lp_ability_r[13] == $past(link_in.word[13])
            && lp_ability_r[11:0] == $past(link_in.word[11:0]))
        else $error("partner ability fields not captured");

    a_lpa_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        !lp_ability_r[12])
        else $error("partner reserved bit set");

    a_lpa_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !link_in.base_vld |=> $stable(lp_ability_r))
        else $error("partner ability changed without page");

    a_pd_set: assert property (@(posedge sys_clk) disable iff (!rstn)
        link_in.pd_fault |=> pd_fault_r)
        else $error("parallel fault not latched");

    a_pd_clear_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        rd_exp && !link_in.pd_fault |=> !pd_fault_r)
        else $error("parallel fault not cleared by read");

    a_pr_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        page_rcvd_r && !rd_exp |=> page_rcvd_r)
        else $error("page received dropped before read");

    a_exp_fields: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_read_exp |=> mgmt_rdata_r[`ANG_EXP_LPNP] == $past(lp_ability_r[`ANG_LPA_NP])
            && mgmt_rdata_r[`ANG_EXP_LPAN] == $past(link_in.an_able)
            && mgmt_rdata_r[15:5] == 11'h000)
        else $error("expansion partner bits wrong");

    a_exp_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_read_exp |=> mgmt_rdata_r[`ANG_EXP_PD] == $past(pd_fault_r)
            && mgmt_rdata_r[`ANG_EXP_PR] == $past(page_rcvd_r))
        else $error("expansion flags not reported");

    a_np_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_nptx |=> np_tx_word_r == ($past(mreq.wdata) & `ANG_NPTX_WMASK))
        else $error("next page write wrong");

    a_np_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_nptx |=> $stable(np_tx_word_r))
        else $error("next page changed without write");

    a_np_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        !np_tx_word_r[14] && !np_tx_word_r[`ANG_NPTX_TOG])
        else $error("next page stored read-only bit set");

    a_lpnp_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
        link_in.np_vld |=> lp_np_r == $past(link_in.word))
        else $error("partner next page not captured");

    a_lpnp_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !link_in.np_vld |=> $stable(lp_np_r))
        else $error("partner next page changed without page");

    a_rxerr_sat: assert property (@(posedge sys_clk) disable iff (!rstn)
        link_in.rx_er && rx_err_cnt_r == `ANG_RXERR_MAX
            |=> rx_err_cnt_r == `ANG_RXERR_MAX)
        else $error("receive error counter wrapped");

    a_rxerr_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_read_rxerr |=> mgmt_rvalid_r && mgmt_rdata_r == $past(rx_err_cnt_r))
        else $error("receive error count not read back");

    a_jab_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        !wr_ics |=> $stable(jabber_irq_en_r))
        else $error("jabber enable changed without write");

    a_ics_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_read_ics |=> mgmt_rdata_r == {$past(jabber_irq_en_r), 15'h0000})
        else $error("interrupt control read wrong");

endmodule // ang_regs
`default_nettype wire

// file: verilog/ang_defs.svh
`ifndef ANG_DEFS_SVH
`define ANG_DEFS_SVH

// register offsets on the management port
`define ANG_OFF_ADV      5'h04
`define ANG_OFF_LPA      5'h05
`define ANG_OFF_EXP      5'h06
`define ANG_OFF_NPTX     5'h07
`define ANG_OFF_LPNP     5'h08
`define ANG_OFF_RXERR    5'h15
`define ANG_OFF_ICS      5'h1B

// advertisement register
`define ANG_ADV_RST      16'h0021
`define ANG_ADV_WMASK    16'hA5FF
`define ANG_ADV_PAUSE    10
`define ANG_ADV_T4       9
`define ANG_ADV_TXFD     8
`define ANG_ADV_TX       7
`define ANG_ADV_10FD     6
`define ANG_ADV_10       5

// link partner base page
`define ANG_LPA_RST      16'h0001
`define ANG_LPA_MASK     16'hEFFF
`define ANG_LPA_ACK      16'h4000
`define ANG_LPA_NP       15

// outgoing next page
`define ANG_NPTX_RST     16'h2001
`define ANG_NPTX_WMASK   16'hB7FF
`define ANG_NPTX_TOG     11

// link partner next page
`define ANG_LPNP_RST     16'h0000

// expansion register
`define ANG_EXP_PD       4
`define ANG_EXP_LPNP     3
`define ANG_EXP_NPABLE   2
`define ANG_EXP_PR       1
`define ANG_EXP_LPAN     0

// receive error counter
`define ANG_RXERR_RST    16'h0000
`define ANG_RXERR_MAX    16'hFFFF

// interrupt control/status
`define ANG_ICS_JAB_EN   15

`endif

// file: verilog/ang_pkg.sv
`default_nettype none
package ang_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } ang_mreq_t;

    typedef struct packed {
        logic        base_vld;
        logic        np_vld;
        logic [15:0] word;
        logic        page_rcvd;
        logic        pd_fault;
        logic        an_able;
        logic        tx_toggle;
        logic        rx_er;
    } ang_link_t;

endpackage
`default_nettype wire

// file: testbench/ang_smc_model.sv
`default_nettype none
module ang_smc_model
(
    input  wire logic             sys_clk,
    output var ang_pkg::ang_mreq_t mreq
);
    timeunit 1ns;
    timeprecision 1ps;

    initial mreq = '0;

    // one request per call; qualifiers held across the sampling edge
    task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        mreq.rd    = ~w;
        mreq.wr    = w;
        mreq.addr  = a;
        mreq.wdata = d;
        @(posedge sys_clk);
        #1;
        // idle lines take the inverse so a stale value never looks valid
        mreq = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // ang_smc_model
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               sys_clk;
    logic               rstn;
    logic               speed_strap;
    logic               duplex_strap;
    ang_pkg::ang_mreq_t mreq;
    ang_pkg::ang_link_t link_in;
    logic [15:0]        mgmt_rdata_r;
    logic               mgmt_rvalid_r;
    logic [15:0]        adv_word_r;
    logic [15:0]        np_tx_word_r;
    logic               jabber_irq_en_r;
    logic [15:0]        exp_q[$];
    logic [15:0]        exp_v;
    logic [15:0]        d;
    logic [15:0]        errs;
    logic [31:0]        seed;
    int                 n_mismatch;
    int                 num_checks;
    int                 cycles;

    ang_regs dut (.sys_clk(sys_clk), .rstn(rstn), .speed_strap(speed_strap),
        .duplex_strap(duplex_strap), .mreq(mreq), .link_in(link_in),
        .mgmt_rdata_r(mgmt_rdata_r), .mgmt_rvalid_r(mgmt_rvalid_r), .adv_word_r(adv_word_r),
        .np_tx_word_r(np_tx_word_r), .jabber_irq_en_r(jabber_irq_en_r));
    ang_smc_model smc (.sys_clk(sys_clk), .mreq(mreq));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        smc.access(1'b0, a, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        smc.access(1'b1, a, v);
    endtask

    // two spare edges let a pending read answer land before reset drops
    task automatic do_reset(input logic sp, input logic dp);
        repeat (2) step();
        rstn = 1'b0;
        speed_strap = sp;
        duplex_strap = dp;
        repeat (16) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        step();
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    // answers come back in request order, so the oldest note is the one due
    always @(negedge sys_clk)
    begin
        if (mgmt_rvalid_r === 1'b1)
        begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~mgmt_rdata_r;
            `CHK(mgmt_rdata_r, exp_v)
        end
    end

    initial
    begin
        seed = 32'h2F29478E;
        n_mismatch = 0;
        num_checks = 0;
        cycles = 0;
        rstn = 1'b0;
        speed_strap = 1'b0;
        duplex_strap = 1'b0;
        link_in = '0;
        for (int s = 0; s < 4; s++)
        begin
            do_reset(s[1], s[0]);
            rd(5'h04, 16'h0021 | {7'h00, s[1] & s[0], s[1], s[0], 6'h00});
            rd(5'h05, 16'h0001);
            rd(5'h06, 16'h0004);
            rd(5'h07, 16'h2001);
            rd(5'h08, 16'h0000);
            rd(5'h15, 16'h0000);
            rd(5'h1B, 16'h0000);
            rd(5'h00, 16'h0000);
            $display("test reset values %0d done", s);
        end
        for (int i = 0; i < 8; i++)
        begin
            d = rnd();
            link_in.tx_toggle = d[3];
            wr(5'h04, d);
            wr(5'h07, d);
            wr(5'h1B, d);
            for (int k = 5; k < 9; k++)
                if (k != 7)
                    wr(5'(k), d);
            wr(5'h15, d);
            wr(5'h1F, d);
            rd(5'h04, d & 16'hA5FF);
            rd(5'h07, (d & 16'hB7FF) | {4'h0, d[3], 11'h000});
            rd(5'h1B, {d[15], 15'h0000});
            rd(5'h05, 16'h0001);
            rd(5'h06, 16'h0004);
            rd(5'h08, 16'h0000);
            rd(5'h15, 16'h0000);
            `CHK(adv_word_r, d & 16'hA5FF)
            `CHK(np_tx_word_r, d & 16'hB7FF)
            `CHK(jabber_irq_en_r, d[15])
        end
        $display("test writes done");
        errs = 16'h0000;
        for (int i = 0; i < 6; i++)
        begin
            d = rnd();
            step();
            link_in.base_vld = 1'b1;
            link_in.word = d;
            link_in.page_rcvd = 1'b1;
            link_in.pd_fault = 1'b1;
            link_in.an_able = d[0];
            step();
            link_in.base_vld = 1'b0;
            link_in.page_rcvd = 1'b0;
            link_in.pd_fault = 1'b0;
            link_in.np_vld = 1'b1;
            link_in.word = ~d;
            step();
            link_in.np_vld = 1'b0;
            link_in.word = d ^ 16'h5A5A;
            rd(5'h05, (d & 16'hEFFF) | 16'h4000);
            rd(5'h08, ~d);
            rd(5'h06, {11'h000, 1'b1, d[15], 1'b1, 1'b1, d[0]});
            rd(5'h06, {11'h000, 1'b0, d[15], 1'b1, 1'b0, d[0]});
            fork
                rd(5'h06, {11'h000, 1'b0, d[15], 1'b1, 1'b0, d[0]});
                begin
                    step();
                    link_in.pd_fault = 1'b1;
                    link_in.page_rcvd = 1'b1;
                    step();
                    link_in.pd_fault = 1'b0;
                    link_in.page_rcvd = 1'b0;
                end
            join
            rd(5'h06, {11'h000, 1'b1, d[15], 1'b1, 1'b1, d[0]});
            link_in.rx_er = 1'b1;
            repeat (int'(d[3:0]) + 1) step();
            link_in.rx_er = 1'b0;
            errs = errs + {12'h000, d[3:0]} + 16'h0001;
            rd(5'h15, errs);
        end
        $display("test link pages done");
        link_in.rx_er = 1'b1;
        repeat (65535) step();
        link_in.rx_er = 1'b0;
        rd(5'h15, 16'hFFFF);
        $display("test counter saturation done");
        repeat (4) step();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
